// file: core/comc_counter_ctrl.sv
// Operating mode control of one counter: arming, gating, triggering,
// reload source choice and end-of-cycle stop or disarm.
// Assumes srcEdge is a one-cycle strobe per active-going source edge and
// that all inputs are synchronous to clk.
`timescale 1ns/10ps
// Function
// - Mode comes from special-gate, reload-source, repetition and gate-control bits.
// - Level-gated single shot counts only edges while gate is active.
// - Single-shot strobes reload from load register at terminal count, then disarm.
// - Hardware-triggered strobe counts from first source edge after gate edge.
// - After disarm, restart needs arm then gate edge; gate ignored once triggered.
// - Gate edges on a disarmed counter are ignored in edge modes.
// - Ungated rate generator repeats terminal counts, reloading from load register.
// - Level-gated rate generator counts only edges while gate active.
// - One-shot starts on gate edge, stops at terminal count, stays armed.
// - Delayed pulse reloads hold then load register, then disarms.
// - Level-gated delayed pulse counts only during active gate.
// - Triggered delayed pulse ignores gate until second terminal count, then disarms.
// - Reload-source without special-gate alternates load and hold reloads.
// - Gate-select modes reload load register if gate low, hold if high.
// - Retrigger edge copies counter to hold, then reloads from load register.
// - Gate-select mode counts twice or repeatedly; gate never qualifies edges.
// - Edge-gated single-count modes start on gate edge, stop at next terminal count.
// - Edge-gated two-count modes start on gate edge, stop at second terminal count.
// - Initial count sets delay, hold register sets pulse length.
// - A counter at terminal count always takes the next source edge.
// - With reload-source but not special-gate, first terminal count after arm reloads from hold register.
module comc_counter_ctrl
  import comc_pkg::*;
#(
  parameter int W = COMC_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire comc_mode_sel_t modeSel,
  input wire logic srcEdge,
  input wire logic gateLvl,
  input wire logic armCmd,
  input wire logic disarmCmd,
  input wire logic loadCmd,
  input wire logic loadWr,
  input wire logic holdWr,
  input wire logic [W-1:0] wrData,
  output logic [W-1:0] countVal,
  output logic [W-1:0] holdVal,
  output logic [W-1:0] loadVal,
  output logic armed,
  output logic counting,
  output logic terminalCount,
  output logic tcEvent,
  output logic modeReserved
);

  localparam logic [W-1:0] TC_VAL = W'(COMC_TC_VALUE);

  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] holdReg;
    logic [W-1:0] loadReg;
    comc_run_t run;
    comc_phase_t phase;
    logic reloadPend;
    logic armedFlag;
    logic countingFlag;
    logic tcFlag;
    logic tcPulse;
    logic reservedFlag;
  } comc_ctrl_state_t;

  comc_ctrl_state_t stateFf;
  comc_ctrl_state_t nxt_state;
  comc_mode_dec_t dec;
  logic gateActive;
  logic gateEdge;
  logic atTc;
  logic qualified;
  logic lastOfPair;
  logic stopNow;
  logic [W-1:0] reloadVal;

  comc_mode_decode u_decode (
    .modeSel(modeSel),
    .modeDec(dec)
  );

  comc_gate_edge u_gate (
    .clk(clk),
    .rstn(rstn),
    .en(en),
    .gateLvl(gateLvl),
    .invertGate(dec.invertGate),
    .gateActive(gateActive),
    .gateEdge(gateEdge)
  );

  always_comb begin
    nxt_state = stateFf;
    nxt_state.tcPulse = 1'b0;
    atTc = (stateFf.count == TC_VAL);
    lastOfPair = (stateFf.phase == PHASE_SECOND);

    // Edge qualification from the run state left by earlier cycles
    case (stateFf.run)
      RUN_COUNTING: begin
        qualified = !dec.levelGate || gateActive;
      end
      RUN_WAIT_GATE: begin
        qualified = 1'b0;
      end
      RUN_DISARMED: begin
        qualified = 1'b0;
      end
      default: begin
        qualified = 1'b0;
      end
    endcase
    if (dec.reserved) begin
      qualified = 1'b0;
    end

    // Reload source at terminal count
    if (dec.gateSelReload) begin
      reloadVal = gateLvl ? stateFf.holdReg : stateFf.loadReg;
    end else if (dec.alternateReload) begin
      // Hold value after the first count sets the pulse width
      reloadVal = lastOfPair ? stateFf.loadReg : stateFf.holdReg;
    end else begin
      reloadVal = stateFf.loadReg;
    end

    // Whether this terminal count ends the count cycle
    stopNow = dec.endOnce
      || (dec.endTwice && lastOfPair)
      || (dec.edgeGate && dec.endRepeat && (!dec.alternateReload || lastOfPair));

    // Gate edges only matter to an armed counter
    if (gateEdge && (stateFf.run != RUN_DISARMED) && !dec.reserved) begin
      if (dec.retrigger) begin
        nxt_state.holdReg = stateFf.count;
        nxt_state.reloadPend = 1'b1;
        if (dec.edgeGate) begin
          nxt_state.run = RUN_COUNTING;
        end
      end else if (dec.edgeGate && (stateFf.run == RUN_WAIT_GATE)) begin
        // Later edges fall through: gate is ignored once triggered
        nxt_state.run = RUN_COUNTING;
      end
    end

    if (srcEdge) begin
      if (atTc) begin
        // Terminal count is left even when stopped, disarmed or gated off
        nxt_state.count = reloadVal;
        nxt_state.tcPulse = 1'b1;
        nxt_state.reloadPend = 1'b0;
        if (dec.alternateReload || dec.endTwice) begin
          nxt_state.phase = lastOfPair ? PHASE_FIRST : PHASE_SECOND;
        end
        if (stopNow && (stateFf.run != RUN_DISARMED)) begin
          if (dec.endOnce || dec.endTwice) begin
            nxt_state.run = RUN_DISARMED;
          end else begin
            nxt_state.run = RUN_WAIT_GATE;
          end
        end
      end else if (qualified) begin
        if (stateFf.reloadPend) begin
          // Counting resumes only on the edge after this load
          nxt_state.count = stateFf.loadReg;
          nxt_state.reloadPend = 1'b0;
        end else begin
          nxt_state.count = stateFf.count - TC_VAL;
        end
      end
    end

    // Host commands take effect after the edge work of the same cycle
    if (armCmd) begin
      nxt_state.run = dec.edgeGate ? RUN_WAIT_GATE : RUN_COUNTING;
      nxt_state.phase = PHASE_FIRST;
      nxt_state.reloadPend = 1'b0;
    end
    if (disarmCmd) begin
      nxt_state.run = RUN_DISARMED;
    end
    if (loadCmd) begin
      nxt_state.count = stateFf.loadReg;
    end
    if (loadWr) begin
      nxt_state.loadReg = wrData;
    end
    if (holdWr) begin
      nxt_state.holdReg = wrData;
    end

    nxt_state.armedFlag = (nxt_state.run != RUN_DISARMED);
    nxt_state.countingFlag = (nxt_state.run == RUN_COUNTING);
    nxt_state.tcFlag = (nxt_state.count == TC_VAL);
    nxt_state.reservedFlag = dec.reserved;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stateFf.count <= W'(COMC_RST_COUNT);
      stateFf.holdReg <= W'(COMC_RST_HOLD);
      stateFf.loadReg <= W'(COMC_RST_LOAD);
      stateFf.run <= RUN_DISARMED;
      stateFf.phase <= PHASE_FIRST;
      stateFf.reloadPend <= 1'b0;
      stateFf.armedFlag <= 1'b0;
      stateFf.countingFlag <= 1'b0;
      stateFf.tcFlag <= 1'b0;
      stateFf.tcPulse <= 1'b0;
      stateFf.reservedFlag <= 1'b0;
    end else if (en) begin
      stateFf <= nxt_state;
    end
  end

  always_comb begin
    countVal = stateFf.count;
    holdVal = stateFf.holdReg;
    loadVal = stateFf.loadReg;
    armed = stateFf.armedFlag;
    counting = stateFf.countingFlag;
    terminalCount = stateFf.tcFlag;
    tcEvent = stateFf.tcPulse;
    modeReserved = stateFf.reservedFlag;
  end

endmodule : comc_counter_ctrl

// file: pkg/comc_pkg.sv
// Shared constants and carriers for the counter operating mode control block.
// Assumes one clock domain; every user of this package imports it whole.
package comc_pkg;

  localparam int COMC_CNT_W = 16;
  localparam int COMC_TC_VALUE = 1;
  localparam int COMC_RST_COUNT = 0;
  localparam int COMC_RST_LOAD = 0;
  localparam int COMC_RST_HOLD = 0;

  // Gate control field encodings
  localparam logic [2:0] COMC_GATE_NONE = 3'h0;
  localparam logic [2:0] COMC_GATE_LEVEL_LO = 3'h5;
  localparam logic [2:0] COMC_GATE_EDGE_HI = 3'h6;
  localparam logic [2:0] COMC_GATE_EDGE_LO = 3'h7;

  typedef struct packed {
    logic specialGateBit;
    logic reloadSourceBit;
    logic repetitionBit;
    logic [2:0] gateControlField;
  } comc_mode_sel_t;

  typedef struct packed {
    logic reserved;
    logic noGate;
    logic levelGate;
    logic edgeGate;
    logic invertGate;
    logic alternateReload;
    logic gateSelReload;
    logic retrigger;
    logic endOnce;
    logic endTwice;
    logic endRepeat;
  } comc_mode_dec_t;

  typedef enum logic [1:0] {
    RUN_DISARMED,
    RUN_WAIT_GATE,
    RUN_COUNTING
  } comc_run_t;

  typedef enum logic {
    PHASE_FIRST,
    PHASE_SECOND
  } comc_phase_t;

  typedef struct packed {
    logic gatePrev;
  } comc_gate_state_t;

endpackage : comc_pkg

// file: core/comc_mode_decode.sv
// Decodes the mode selection bits into the behaviour flags of one counter.
// Purely combinational; the caller registers anything it exports.
`timescale 1ns/10ps
module comc_mode_decode
  import comc_pkg::*;
(
  input wire comc_mode_sel_t modeSel,
  output comc_mode_dec_t modeDec
);

  logic sg;
  logic rs;
  logic rp;
  logic [2:0] gc;

  always_comb begin
    sg = modeSel.specialGateBit;
    rs = modeSel.reloadSourceBit;
    rp = modeSel.repetitionBit;
    gc = modeSel.gateControlField;
    modeDec.noGate = (gc == COMC_GATE_NONE);
    modeDec.edgeGate = (gc == COMC_GATE_EDGE_HI) || (gc == COMC_GATE_EDGE_LO);
    modeDec.levelGate = !modeDec.noGate && !modeDec.edgeGate;
    modeDec.invertGate = (gc == COMC_GATE_LEVEL_LO) || (gc == COMC_GATE_EDGE_LO);
    // Undefined combinations inhibit counting rather than guess a behaviour
    modeDec.reserved = (sg && !rs && modeDec.noGate) || (sg && rs && !modeDec.noGate);
    modeDec.alternateReload = !sg && rs;
    modeDec.gateSelReload = sg && rs;
    modeDec.retrigger = sg && !rs;
    modeDec.endOnce = !rs && !rp;
    modeDec.endTwice = rs && !rp;
    modeDec.endRepeat = rp;
  end

endmodule : comc_mode_decode

// file: core/comc_gate_edge.sv
// Gate polarity and active-going edge detection for one counter.
// Assumes the gate level is already synchronous to clk.
`timescale 1ns/10ps
module comc_gate_edge
  import comc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic gateLvl,
  input wire logic invertGate,
  output logic gateActive,
  output logic gateEdge
);

  comc_gate_state_t stateFf;
  comc_gate_state_t nxt_state;

  always_comb begin
    gateActive = gateLvl ^ invertGate;
    // Sampled on the same clock that carries the source edge strobes
    gateEdge = gateActive && !stateFf.gatePrev;
    nxt_state = stateFf;
    nxt_state.gatePrev = gateActive;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stateFf <= '0;
    end else if (en) begin
      stateFf <= nxt_state;
    end
  end

endmodule : comc_gate_edge

// file: sim/comc_counter_ctrl_assertions.sv
// Port-level properties of the counter mode control block.
// Assumes one clock domain, rstn asynchronous and active low.
`timescale 1ns/10ps
module comc_counter_ctrl_assertions
  import comc_pkg::*;
#(
  parameter int W = COMC_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire comc_mode_sel_t modeSel,
  input wire logic srcEdge,
  input wire logic gateLvl,
  input wire logic armCmd,
  input wire logic disarmCmd,
  input wire logic loadCmd,
  input wire logic holdWr,
  input wire logic [W-1:0] countVal,
  input wire logic [W-1:0] holdVal,
  input wire logic armed,
  input wire logic counting,
  input wire logic terminalCount,
  input wire logic tcEvent,
  input wire logic modeReserved
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic sg = modeSel.specialGateBit;
  wire logic [2:0] gc = modeSel.gateControlField;
  wire logic resv = sg && (modeSel.reloadSourceBit ? gc != 3'h0 : gc == 3'h0);
  // Polarity applied as the design does, so edges line up with its detector
  wire logic gAct = gateLvl ^ (gc == 3'h5 || gc == 3'h7);

  tc_level_a: assert property (terminalCount == (countVal == W'(COMC_TC_VALUE)))
    else $error("terminal count flag disagrees with count");
  tc_exit_a: assert property (en && srcEdge && terminalCount && !loadCmd |=> tcEvent)
    else $error("edge at terminal count not taken");
  tc_cause_a: assert property (tcEvent |-> $past(terminalCount) && $past(srcEdge))
    else $error("reload pulse without terminal count edge");
  idle_frozen_a: assert property (en && !armed && !terminalCount && !loadCmd
    |=> $stable(countVal))
    else $error("disarmed counter moved");
  idle_stays_a: assert property (en && !armed && !armCmd |=> !armed && !counting)
    else $error("counter armed itself");
  arm_waits_a: assert property (en && armCmd && !disarmCmd && !armed
    && !sg && gc[2:1] == 2'b11 |=> armed && !counting)
    else $error("edge mode counted before gate edge");
  ungated_dec_a: assert property (en && srcEdge && counting && !terminalCount
    && !loadCmd && !sg && gc == 3'h0 |=> countVal == $past(countVal) - W'(1))
    else $error("ungated count did not step");
  level_hold_a: assert property (en && srcEdge && !terminalCount && !loadCmd
    && !sg && gc == 3'h1 && !gateLvl |=> $stable(countVal))
    else $error("edge counted with gate inactive");
  retrig_hold_a: assert property (en && $past(en) && armed && sg && !modeSel.reloadSourceBit
    && gc != 3'h0 && !holdWr && gAct && !$past(gAct) |=> holdVal == $past(countVal))
    else $error("retrigger did not copy count to hold");
  reserved_flag_a: assert property (en |=> modeReserved == $past(resv))
    else $error("reserved flag wrong");
  cover property (tcEvent && !armed);
  cover property (armed && !counting);
  cover property (modeReserved);
  cover property (en && armed && sg && gAct && !$past(gAct));
endmodule : comc_counter_ctrl_assertions

bind comc_counter_ctrl comc_counter_ctrl_assertions #(.W(W)) chkI (.clk(clk), .rstn(rstn),
  .en(en), .modeSel(modeSel), .srcEdge(srcEdge), .gateLvl(gateLvl), .armCmd(armCmd),
  .disarmCmd(disarmCmd), .loadCmd(loadCmd), .holdWr(holdWr), .countVal(countVal),
  .holdVal(holdVal), .armed(armed),
  .counting(counting), .terminalCount(terminalCount), .tcEvent(tcEvent),
  .modeReserved(modeReserved));

// file: sim/comc_counter_ctrl_bench.sv
// Self-checking bench: a small reference model runs every non-reserved
// mode it knows against the design. Assumes package and design compiled.
`timescale 1ns/10ps
module comc_counter_ctrl_bench import comc_pkg::*;;
  logic clk = 1'b0, rstn = 1'b0, srcEdge = 1'b0, gateLvl = 1'b0;
  logic armCmd = 1'b0, disarmCmd = 1'b0, loadCmd = 1'b0, loadWr = 1'b0, holdWr = 1'b0;
  comc_mode_sel_t modeSel = '0;
  logic [15:0] wrData = 16'h0000, countVal, holdVal, loadVal;
  logic armed, counting, terminalCount, tcEvent, modeReserved;
  int err_count = 0, n_checks = 0, seed = 50, mc, ml, mh, k, t;
  bit ma, run, ph, gp, rs, rep, edg, lvl, sgs;
  logic [5:0] m;
  // Retriggering gets a directed test at the end; the model has no hold copy
  localparam logic [5:0] MODES [14] = '{6'h00, 6'h01, 6'h06, 6'h08, 6'h09, 6'h0e, 6'h10,
    6'h11, 6'h16, 6'h18, 6'h19, 6'h1e, 6'h30, 6'h38};

  comc_counter_ctrl dut (.clk(clk), .rstn(rstn), .en(1'b1), .modeSel(modeSel),
    .srcEdge(srcEdge), .gateLvl(gateLvl), .armCmd(armCmd), .disarmCmd(disarmCmd),
    .loadCmd(loadCmd), .loadWr(loadWr), .holdWr(holdWr), .wrData(wrData),
    .countVal(countVal), .holdVal(holdVal), .loadVal(loadVal), .armed(armed),
    .counting(counting), .terminalCount(terminalCount), .tcEvent(tcEvent),
    .modeReserved(modeReserved));

  initial forever #50 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Extra idle cycle so the same strobe is never re-raised in one step
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask : pulse

  // Gate settles a cycle ahead so its edge precedes the source edge
  task automatic src(input bit g);
    bit tc;
    gateLvl = g;
    if (g && !gp && ma && edg && !run) run = 1'b1;
    gp = g;
    @(negedge clk);
    srcEdge = 1'b1;
    tc = (mc == 1);
    if (tc) begin
      mc = sgs ? (g ? mh : ml) : ((rs && !ph) ? mh : ml);
      if (rs) ph = !ph;
      if (!rs || !ph) begin
        if (edg) run = 1'b0;
        if (!rep) ma = 1'b0;
      end
    end else if (ma && run && (!lvl || g)) mc--;
    @(negedge clk);
    srcEdge = 1'b0;
    chk(countVal, 16'(mc));
    chk(tcEvent, tc);
    chk(terminalCount, mc == 1);
    chk(armed, ma);
    chk(counting, ma && run);
  endtask : src

  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    chk(countVal, 16'h0000);
    chk(armed, 1'b0);
    for (k = 0; k < 64; k++) begin
      modeSel = 6'(k);
      @(negedge clk);
      chk(modeReserved, k[5] && (k[4] ? k[2:0] != 3'h0 : k[2:0] == 3'h0));
    end
    $display("Reserved scan done");
    for (k = 0; k < 14; k++) begin
      m = MODES[k];
      modeSel = m;
      rs = m[4];
      rep = m[3];
      sgs = m[5] && m[4];
      edg = (m[2:1] == 2'b11);
      lvl = (m[2:0] != 3'h0) && !edg;
      pulse(disarmCmd);
      ml = 2 + {$random(seed)} % 4;
      mh = 2 + {$random(seed)} % 4;
      wrData = 16'(ml);
      pulse(loadWr);
      wrData = 16'(mh);
      pulse(holdWr);
      pulse(loadCmd);
      mc = ml;
      chk(loadVal, 16'(ml));
      chk(holdVal, 16'(mh));
      chk(countVal, 16'(mc));
      pulse(armCmd);
      ma = 1'b1;
      run = !edg;
      ph = 1'b0;
      chk(counting, run);
      for (t = 0; t < 24; t++) src({$random(seed)} % 2);
      $display("Mode %h done", m);
    end
    // Level-gated rate mode with retrigger; first gate edge lands while disarmed
    gateLvl = 1'b0;
    pulse(disarmCmd);
    modeSel = 6'h29;
    gateLvl = 1'b1;
    ml = 4 + {$random(seed)} % 4;
    wrData = 16'(ml);
    pulse(loadWr);
    pulse(loadCmd);
    chk(holdVal, 16'(mh));
    chk(countVal, 16'(ml));
    pulse(armCmd);
    chk(counting, 1'b1);
    pulse(srcEdge);
    chk(countVal, 16'(ml - 1));
    gateLvl = 1'b0;
    @(negedge clk);
    gateLvl = 1'b1;
    @(negedge clk);
    chk(holdVal, 16'(ml - 1));
    pulse(srcEdge);
    chk(countVal, 16'(ml));
    pulse(srcEdge);
    chk(countVal, 16'(ml - 1));
    $display("Retrigger done");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule : comc_counter_ctrl_bench
